// [rtl/ctab_top.sv]
// Transmit abort control, interrupt enables and message buffers on Avalon-MM.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "ctab_map.svh"

// Notes on behaviour
// - Empty-interrupt enables stay at reset in init mode; written only outside it.
// - Abort requests stay at reset in init mode; written only outside it.
// - Three enable bits gate each buffer's transmitter-empty interrupt request.
// - Abort granted only before transmission starts or after it failed.
// - Extended layout: 11 identifier bits first, SRR and IDE, 18 more identifier bits, RTR last.
// - Extended buffers carry SRR and IDE both set.
// - RTR is read from the position matching standard or extended format.
// - Eight data bytes, MSB at bit 7; length byte holds DLC low nibble.
// - A transmit buffer is reachable only when empty and selected.
module ctab_top (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    input wire logic [1:0] eng_sel_i,
    input wire logic [2:0] eng_byte_idx_i,
    input wire ctab_pkg::ctab_eng_s [2:0] eng_evt_i,
    output ctab_pkg::ctab_frame_s eng_frame_o,
    output logic [7:0] eng_byte_o,
    output logic [2:0] eng_pending_o
);
    // ======================================================================
    // Reset and bus handshake
    // ======================================================================
    logic rst_n;
    logic ack_q;
    logic req;
    logic wr_go;
    logic rd_go;
    logic lane0;
    logic [5:0] widx;
    logic [7:0] wbyte;

    ctab_rst_sync u_rst (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .rst_n_o(rst_n)
    );

    // A request is taken on its first cycle and answered on the next.
    assign req = avs_read_i | avs_write_i;
    assign widx = avs_address_i[7:2];
    assign lane0 = avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];
    assign wr_go = avs_write_i & ~avs_waitrequest_o & lane0;
    assign rd_go = avs_read_i & avs_waitrequest_o;

    // Waitrequest drops for exactly one cycle per request.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest_o <= 1'b1;
            ack_q <= 1'b0;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
            ack_q <= req & avs_waitrequest_o;
        end
    end

    // ======================================================================
    // Register decode
    // ======================================================================
    logic hit_ctrl;
    logic hit_tflg;
    logic hit_tier;
    logic hit_tarq;
    logic hit_tbsel;
    logic hit_ist;
    logic hit_imsk;
    logic hit_buf;
    logic buf_map;
    logic [3:0] bidx;

    assign hit_ctrl = (widx == `CTAB_W_CTRL);
    assign hit_tflg = (widx == `CTAB_W_TFLG);
    assign hit_tier = (widx == `CTAB_W_TIER);
    assign hit_tarq = (widx == `CTAB_W_TARQ);
    assign hit_tbsel = (widx == `CTAB_W_TBSEL);
    assign hit_ist = (widx == `CTAB_W_IST);
    assign hit_imsk = (widx == `CTAB_W_IMSK);
    assign hit_buf = (widx >= `CTAB_W_BUF0) && (widx <= `CTAB_W_BUFN);
    assign bidx = 4'(widx - `CTAB_W_BUF0);
    // The two slots between the payload and the length byte are a gap.
    assign buf_map = hit_buf && ((bidx < `CTAB_B_GAP) || (bidx == `CTAB_B_DLR));

    // ======================================================================
    // Initialization mode
    // ======================================================================
    logic init_rq_q;
    logic init_ak_q;
    logic init_both;
    logic init_none;

    // The acknowledge trails the request by a cycle. Holding keys on the
    // request alone, so the registers already sit at reset once both are set.
    assign init_both = init_rq_q & init_ak_q;
    assign init_none = ~init_rq_q & ~init_ak_q;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            init_rq_q <= 1'b0;
            init_ak_q <= 1'b0;
        end else begin
            if (wr_go && hit_ctrl) init_rq_q <= wbyte[`CTAB_INIT_REQUEST_BIT];
            init_ak_q <= init_rq_q;
        end
    end

    // ======================================================================
    // Transmit flags, enables, aborts and buffer select
    // ======================================================================
    logic [2:0] tx_buffer_empty;
    logic [2:0] txe_q;
    logic [2:0] aborted;
    logic [2:0] tier_q;
    logic [2:0] tier_d;
    logic [2:0] tarq_q;
    logic [2:0] tarq_d;
    logic [2:0] taak_q;
    logic [2:0] tbsel_q;
    logic [2:0] sched;
    logic [2:0] acc_oh;
    logic [1:0] acc_idx;
    logic acc_ok;

    // Writing a one to an empty flag hands that buffer to the engine.
    assign sched = (wr_go && hit_tflg) ? (wbyte[2:0] & tx_buffer_empty) : 3'h0;

    // Enables: reset value in init mode, software value outside it.
    assign tier_d = init_rq_q ? `CTAB_TIER_RST :
        (wr_go && hit_tier && init_none) ? wbyte[2:0] : tier_q;

    // Aborts: only queued or active (non-empty) buffers take a request; a buffer that empties
    // for any reason drops its request.
    assign tarq_d = init_rq_q ? `CTAB_TARQ_RST :
        ((wr_go && hit_tarq && init_none) ? (wbyte[2:0] & ~tx_buffer_empty) : tarq_q)
        & ~tx_buffer_empty & ~aborted;

    // Only the lowest selected empty buffer opens the window.
    assign acc_oh = (tbsel_q & tx_buffer_empty) & ~((tbsel_q & tx_buffer_empty) - 3'h1);
    assign acc_ok = |acc_oh;
    assign acc_idx = acc_oh[0] ? 2'd0 : (acc_oh[1] ? 2'd1 : 2'd2);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tier_q <= `CTAB_TIER_RST;
            tarq_q <= `CTAB_TARQ_RST;
            taak_q <= 3'h0;
            tbsel_q <= 3'h0;
            txe_q <= `CTAB_TXE_RST;
        end else begin
            tier_q <= tier_d;
            tarq_q <= tarq_d;
            taak_q <= (taak_q & ~sched) | aborted;
            if (wr_go && hit_tbsel) tbsel_q <= wbyte[2:0];
            txe_q <= tx_buffer_empty;
        end
    end

    // ======================================================================
    // Message buffers
    // ======================================================================
    logic [119:0] bytes [0:2];

    for (genvar g = 0; g < 3; g++) begin : g_buf
        ctab_txbuf u_buf (
            .clock_i(clock_i),
            .rst_n_i(rst_n),
            .we_i(wr_go & buf_map & acc_oh[g]),
            .idx_i(bidx),
            .wdata_i(wbyte),
            .sched_i(sched[g]),
            .abort_i(tarq_q[g]),
            .eng_i(eng_evt_i[g]),
            .bytes_o(bytes[g]),
            .txe_o(tx_buffer_empty[g]),
            .aborted_o(aborted[g])
        );
    end

    // ======================================================================
    // Interrupt status and mask
    // ======================================================================
    logic [5:0] ist_q;
    logic [5:0] imsk_q;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [5:0] gate;

    // Low half: buffer became empty; high half: abort completed.
    assign ev = {aborted, tx_buffer_empty & ~txe_q};
    assign clr = (wr_go && hit_ist) ? wbyte[5:0] : 6'h00;
    assign gate = {3'h7, tier_q};

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= `CTAB_IRQ_RST;
            imsk_q <= `CTAB_IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~clr) | ev;
            if (wr_go && hit_imsk) imsk_q <= wbyte[5:0];
            irq_o <= |(ist_q & imsk_q & gate);
        end
    end

    // ======================================================================
    // Read data
    // ======================================================================
    logic [7:0] win_byte;
    logic [7:0] rd_byte;
    logic [119:0] acc_bytes;

    assign acc_bytes = bytes[acc_idx];
    // A closed window reads zero.
    assign win_byte = (acc_ok && buf_map) ? acc_bytes[bidx*8 +: 8] : 8'h00;
    assign rd_byte =
        hit_ctrl ? {6'h00, init_ak_q, init_rq_q} :
        hit_tflg ? {5'h00, tx_buffer_empty} :
        hit_tier ? {5'h00, tier_q} :
        hit_tarq ? {5'h00, tarq_q} :
        (widx == `CTAB_W_TAAK) ? {5'h00, taak_q} :
        hit_tbsel ? {5'h00, tbsel_q} :
        hit_ist ? {2'h0, ist_q} :
        hit_imsk ? {2'h0, imsk_q} :
        hit_buf ? win_byte : 8'h00;

    // Data is captured with the request and stands in the answer cycle.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata_o <= {24'h00_0000, rd_byte};
        end
    end

    // ======================================================================
    // Engine view of the selected buffer
    // ======================================================================
    logic [119:0] eb;
    logic [7:0] msg_ident_byte0;
    logic [7:0] msg_ident_byte1;
    logic [7:0] msg_ident_byte2;
    logic [7:0] msg_ident_byte3;
    logic ext;
    ctab_pkg::ctab_frame_s frame_d;

    assign eb = bytes[(eng_sel_i > 2'd2) ? 2'd2 : eng_sel_i];
    assign msg_ident_byte0 = eb[`CTAB_B_MSG_IDENT_BYTE0*8 +: 8];
    assign msg_ident_byte1 = eb[`CTAB_B_MSG_IDENT_BYTE1*8 +: 8];
    assign msg_ident_byte2 = eb[`CTAB_B_MSG_IDENT_BYTE2*8 +: 8];
    assign msg_ident_byte3 = eb[`CTAB_B_MSG_IDENT_BYTE3*8 +: 8];
    assign ext = msg_ident_byte1[`CTAB_IDE_BIT];

    // Identifier bits are packed high first across the first four bytes.
    assign frame_d.ext = ext;
    assign frame_d.id = ext ?
        {msg_ident_byte0, msg_ident_byte1[7:5], msg_ident_byte1[2:0], msg_ident_byte2, msg_ident_byte3[7:1]} :
        {18'h0_0000, msg_ident_byte0, msg_ident_byte1[7:5]};
    assign frame_d.rtr = ext ? msg_ident_byte3[`CTAB_EXT_RTR_BIT] :
        msg_ident_byte1[`CTAB_STD_RTR_BIT];
    assign frame_d.dlc = eb[`CTAB_B_DLR*8 +: 4];

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            eng_frame_o <= '0;
            eng_byte_o <= 8'h00;
            eng_pending_o <= 3'h0;
        end else begin
            eng_frame_o <= frame_d;
            eng_byte_o <= eb[(`CTAB_B_MSG_PAYLOAD_BYTE0 + 4'(eng_byte_idx_i))*8 +: 8];
            eng_pending_o <= ~tx_buffer_empty;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_req_new;
        req && avs_waitrequest_o;
    endsequence
    sequence s_ack;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    a_bus_answer: assert property (s_req_new |=> s_ack)
        else $error("bus request not answered in one cycle");
    a_tier_held: assert property (init_both |=> tier_q == `CTAB_TIER_RST)
        else $error("interrupt enables moved during init mode");
    a_tier_locked: assert property (
        (wr_go && hit_tier && !init_none) |=> tier_q == `CTAB_TIER_RST)
        else $error("interrupt enables written outside normal mode");
    a_tarq_held: assert property (init_both |=> tarq_q == `CTAB_TARQ_RST)
        else $error("abort requests moved during init mode");
    a_irq_gate: assert property (
        (ist_q[0] && imsk_q[0] && tier_q[0]) |=> irq_o)
        else $error("enabled empty event did not interrupt");
    a_irq_quiet: assert property (
        ((ist_q & imsk_q & gate) == 6'h00) |=> !irq_o)
        else $error("interrupt raised with nothing enabled");
    a_abort_flags: assert property (
        aborted[1] |=> (tx_buffer_empty[1] && taak_q[1] && ist_q[4]))
        else $error("abort did not set empty and acknowledge");
    a_rtr_place: assert property (
        1'b1 |=> eng_frame_o.rtr == ($past(ext) ? $past(msg_ident_byte3[0]) : $past(msg_ident_byte1[4])))
        else $error("remote flag read from the wrong position");
    a_win_closed: assert property (
        (s_req_new and (avs_read_i && hit_buf && !acc_ok)) |=> avs_readdata_o == 32'h0)
        else $error("closed buffer window returned data");
    a_srr_ide: assert property (
        (wr_go && hit_buf && acc_oh[0] && bidx == `CTAB_B_MSG_IDENT_BYTE1 && wbyte[3])
        |=> bytes[0][`CTAB_B_MSG_IDENT_BYTE1*8 + `CTAB_SRR_BIT])
        else $error("extended buffer stored SRR clear");
endmodule // ctab_top

// [shared/ctab_map.svh]
// Register offsets, field positions and reset values of the transmit abort block.
`ifndef CTAB_MAP_SVH
`define CTAB_MAP_SVH

// ==========================================================================
// Word indices on the register bus (byte address is four times the index)
// ==========================================================================
`define CTAB_W_CTRL 6'h00
`define CTAB_W_TFLG 6'h01
`define CTAB_W_TIER 6'h02
`define CTAB_W_TARQ 6'h03
`define CTAB_W_TAAK 6'h04
`define CTAB_W_TBSEL 6'h05
`define CTAB_W_IST 6'h06
`define CTAB_W_IMSK 6'h07
`define CTAB_W_BUF0 6'h10
`define CTAB_W_BUFN 6'h1e

// ==========================================================================
// Byte positions inside a message buffer
// ==========================================================================
`define CTAB_B_MSG_IDENT_BYTE0 4'h0
`define CTAB_B_MSG_IDENT_BYTE1 4'h1
`define CTAB_B_MSG_IDENT_BYTE2 4'h2
`define CTAB_B_MSG_IDENT_BYTE3 4'h3
`define CTAB_B_MSG_PAYLOAD_BYTE0 4'h4
`define CTAB_B_GAP 4'hc
`define CTAB_B_DLR 4'he

// ==========================================================================
// Field positions
// ==========================================================================
`define CTAB_INIT_REQUEST_BIT 0
`define CTAB_INIT_ACK_BIT 1
`define CTAB_SRR_BIT 4
`define CTAB_IDE_BIT 3
`define CTAB_STD_RTR_BIT 4
`define CTAB_EXT_RTR_BIT 0
`define CTAB_DLC_MASK 8'h0f

// ==========================================================================
// Reset values
// ==========================================================================
`define CTAB_TXE_RST 3'h7
`define CTAB_TIER_RST 3'h0
`define CTAB_TARQ_RST 3'h0
`define CTAB_IRQ_RST 6'h00

`endif

// [shared/ctab_pkg.sv]
// Types shared by the transmit abort block.
package ctab_pkg;

    // Life of one transmit buffer.
    typedef enum logic [1:0] {
        buf_empty = 2'b00,
        buf_queued = 2'b01,
        buf_active = 2'b10
    } ctab_buf_e;

    // Events reported by the protocol engine for one buffer.
    typedef struct packed {
        logic start;
        logic done;
        logic fail;
    } ctab_eng_s;

    // Decoded frame header handed to the protocol engine.
    typedef struct packed {
        logic ext;
        logic rtr;
        logic [28:0] id;
        logic [3:0] dlc;
    } ctab_frame_s;

endpackage

// [rtl/ctab_rst_sync.sv]
// Reset release synchroniser.
`timescale 1ns/1ps
module ctab_rst_sync (
    input wire logic clock_i,
    input wire logic arst_n_i,
    output logic rst_n_o
);
    logic meta_q;

    // Assert at once, release two edges later.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 1'b0;
            rst_n_o <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            rst_n_o <= meta_q;
        end
    end
endmodule // ctab_rst_sync

// [rtl/ctab_txbuf.sv]
// One transmit message buffer with its queue state.
`timescale 1ns/1ps
`include "ctab_map.svh"
module ctab_txbuf (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [3:0] idx_i,
    input wire logic [7:0] wdata_i,
    input wire logic sched_i,
    input wire logic abort_i,
    input wire ctab_pkg::ctab_eng_s eng_i,
    output logic [119:0] bytes_o,
    output logic txe_o,
    output logic aborted_o
);
    ctab_pkg::ctab_buf_e state_q, state_d;
    logic [7:0] mem_q [0:14];
    logic [7:0] wbyte;

    // Extended frames keep SRR set; the DLC byte keeps only its low nibble.
    assign wbyte = (idx_i == `CTAB_B_MSG_IDENT_BYTE1 && wdata_i[`CTAB_IDE_BIT]) ?
        (wdata_i | (8'h01 << `CTAB_SRR_BIT)) :
        (idx_i == `CTAB_B_DLR) ? (wdata_i & `CTAB_DLC_MASK) : wdata_i;
    assign txe_o = (state_q == ctab_pkg::buf_empty);

    // An abort wins only before the frame starts or after it failed.
    always_comb begin
        state_d = state_q;
        aborted_o = 1'b0;
        unique case (state_q)
            ctab_pkg::buf_empty: if (sched_i) state_d = ctab_pkg::buf_queued;
            ctab_pkg::buf_queued: begin
                if (abort_i) begin
                    state_d = ctab_pkg::buf_empty;
                    aborted_o = 1'b1;
                end else if (eng_i.start) begin
                    state_d = ctab_pkg::buf_active;
                end
            end
            ctab_pkg::buf_active: begin
                if (eng_i.done) state_d = ctab_pkg::buf_empty;
                else if (eng_i.fail) state_d = ctab_pkg::buf_queued;
            end
            default: state_d = ctab_pkg::buf_empty;
        endcase
    end

    // State and storage; storage is cleared so the engine never sees unknowns.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ctab_pkg::buf_empty;
            for (int i = 0; i < 15; i++) mem_q[i] <= 8'h00;
        end else begin
            state_q <= state_d;
            if (we_i) mem_q[idx_i] <= wbyte;
        end
    end

    for (genvar g = 0; g < 15; g++) begin : g_out
        assign bytes_o[g*8 +: 8] = mem_q[g];
    end

    a_active_abort: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == ctab_pkg::buf_active && abort_i && !eng_i.done) |=> !txe_o)
        else $error("abort granted while the frame was on the bus");
endmodule // ctab_txbuf

// [dv/ctab_eng_model.sv]
// Behavioural protocol engine that reports start, done and fail per buffer.
`timescale 1ns/1ps
module ctab_eng_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [1:0] cmd_i,
    input wire logic [1:0] buf_i,
    input wire logic [2:0] pending_i,
    output ctab_pkg::ctab_eng_s [2:0] evt_o
);
    // ==========================================================
    // Event pulses
    // ==========================================================
    // Command 1 starts, 2 completes, 3 fails; an empty buffer is never touched,
    // because a real engine only picks up what the block reports pending.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_o <= '0;
        end else begin
            evt_o <= '0;
            if (cmd_i != 2'h0 && buf_i < 2'h3 && pending_i[buf_i]) begin
                evt_o[buf_i] <= {cmd_i == 2'h1, cmd_i == 2'h2, cmd_i == 2'h3};
            end
        end
    end
endmodule // ctab_eng_model

// [dv/tb_can_tx_abort_and_msg_buffer.sv]
// Self-checking bench for the transmit abort and message buffer block.
`timescale 1ns/1ps
module tb_can_tx_abort_and_msg_buffer;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_req;
    logic irq;
    logic [1:0] eng_sel = 2'h0;
    logic [2:0] eng_idx = 3'h0;
    logic [1:0] eng_cmd = 2'h0;
    logic [1:0] eng_buf = 2'h0;
    ctab_pkg::ctab_eng_s [2:0] eng_evt;
    ctab_pkg::ctab_frame_s frame;
    logic [7:0] eng_byte;
    logic [2:0] pending;
    logic [7:0] exp_q[$];
    logic [7:0] dat[13];
    logic [7:0] id1;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 70218;

    ctab_top ctab_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
        .irq_o(irq), .eng_sel_i(eng_sel), .eng_byte_idx_i(eng_idx), .eng_evt_i(eng_evt),
        .eng_frame_o(frame), .eng_byte_o(eng_byte), .eng_pending_o(pending));

    ctab_eng_model ctab_eng_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .cmd_i(eng_cmd), .buf_i(eng_buf), .pending_i(pending), .evt_o(eng_evt));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clock_i = ~clock_i;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The request stays up until waitrequest is seen low, whatever the latency.
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic r);
        adr <= a;
        wdat <= {24'h0, d};
        rd_en <= r;
        wr_en <= !r;
        @(posedge clock_i);
        while (wait_req !== 1'b0) @(posedge clock_i);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b1);
    endtask

    task automatic eng(input logic [1:0] b, input logic [1:0] c);
        eng_buf <= b;
        eng_cmd <= c;
        @(posedge clock_i);
        eng_cmd <= 2'h0;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Read data is judged only at the edge where the slave answers.
    always @(posedge clock_i) begin
        if (rd_en && wait_req === 1'b0 && exp_q.size() > 0) chk("readdata", exp_q.pop_front(), rdat);
    end

    // A hung handshake ends the run as a failure.
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(8'h04, 8'h07);
        rd(8'h08, 8'h00);
        rd(8'h0c, 8'h00);
        rd(8'h20, 8'h00);
        $display("test reset done");
        wr(8'h08, 8'h03);
        wr(8'h04, 8'h01);
        @(posedge clock_i);
        chk("pending", 3'h1, pending);
        wr(8'h00, 8'h01);
        rd(8'h08, 8'h00);
        wr(8'h08, 8'h07);
        wr(8'h0c, 8'h01);
        rd(8'h08, 8'h00);
        rd(8'h0c, 8'h00);
        wr(8'h00, 8'h00);
        repeat (2) @(posedge clock_i);
        rd(8'h04, 8'h06);
        $display("test init mode done");
        wr(8'h1c, 8'h3f);
        wr(8'h08, 8'h07);
        rd(8'h08, 8'h07);
        wr(8'h0c, 8'h01);
        rd(8'h04, 8'h07);
        rd(8'h10, 8'h01);
        rd(8'h0c, 8'h00);
        rd(8'h18, 8'h09);
        chk("irq", 1'b1, irq);
        wr(8'h18, 8'h3f);
        repeat (2) @(posedge clock_i);
        chk("irq", 1'b0, irq);
        $display("test queued abort done");
        wr(8'h14, 8'h01);
        for (int i = 0; i < 13; i++) dat[i] = 8'($random(seed));
        dat[1] = dat[1] | 8'h08;
        id1 = dat[1] | 8'h10;
        for (int i = 0; i < 13; i++) wr(8'h40 + 8'(i * 4), dat[i]);
        wr(8'h78, dat[12]);
        for (int i = 0; i < 12; i++) rd(8'h40 + 8'(i * 4), (i == 1) ? id1 : dat[i]);
        rd(8'h44, id1);
        rd(8'h70, 8'h00);
        rd(8'h78, {4'h0, dat[12][3:0]});
        eng_idx <= 3'h5;
        repeat (3) @(posedge clock_i);
        chk("frame", {1'b1, dat[3][0], dat[0], id1[7:5], id1[2:0], dat[2], dat[3][7:1],
            dat[12][3:0]}, frame);
        chk("byte", dat[9], eng_byte);
        wr(8'h44, 8'h10);
        repeat (3) @(posedge clock_i);
        chk("ext_rtr", 2'b01, {frame.ext, frame.rtr});
        wr(8'h04, 8'h01);
        rd(8'h40, 8'h00);
        $display("test buffer layout done");
        wr(8'h1c, 8'h01);
        wr(8'h08, 8'h02);
        wr(8'h04, 8'h02);
        eng(2'h1, 2'h1);
        wr(8'h0c, 8'h02);
        rd(8'h0c, 8'h02);
        rd(8'h04, 8'h04);
        repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge clock_i);
        eng(2'h1, 2'h3);
        rd(8'h04, 8'h06);
        rd(8'h10, 8'h02);
        eng(2'h0, 2'h1);
        wr(8'h0c, 8'h01);
        eng(2'h0, 2'h2);
        rd(8'h04, 8'h07);
        rd(8'h10, 8'h02);
        rd(8'h0c, 8'h00);
        chk("irq", 1'b0, irq);
        wr(8'h08, 8'h01);
        repeat (2) @(posedge clock_i);
        chk("irq", 1'b1, irq);
        $display("test active abort done");
        repeat (2) @(posedge clock_i);
        complete_run();
    end
endmodule // tb_can_tx_abort_and_msg_buffer
